// ---- bififo_ctrl_chk.sv ----
// checker of the port B flag and parity control bank
// assumes a bind onto the bank's top module, one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "bififo_ctrl_regs.svh"
module bififo_ctrl_chk (
   input wire logic                      clk,
   input wire logic                      rst_n,
   input wire logic                      port_a_clock,
   input wire logic                      port_b_clock,
   input wire bififo_ctrl_pkg::reg_req_s reg_req,
   input wire logic [31:0]               reg_rdata,
   input wire bififo_ctrl_pkg::flags_s   flag_cond,
   input wire bififo_ctrl_pkg::flags_s   flags,
   input wire logic                      port_b_parity_error_flag,
   input wire logic                      pb_in_valid,
   input wire logic                      pb_in_ready,
   input wire logic                      pb_out_valid,
   input wire logic                      pb_out_ready
);
   import bififo_ctrl_pkg::*;
   logic [17:0] ctrl;
   logic [3:0]  age_a;
   logic [3:0]  age_b;
   logic        a_q;
   logic        b_q;
   logic [3:0]  occ;
   // ------------------------------------------------------------
   // shadow state
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         ctrl <= `CTRL_RESET;
      else if (reg_req.wr && reg_req.addr == `CTRL_OFFSET)
         ctrl <= reg_req.wdata[17:0] & `CTRL_WRITE_MASK;
   end
   // cycles since each port clock pin rose, saturating
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         a_q <= 1'b0;
         b_q <= 1'b0;
         age_a <= 4'hf;
         age_b <= 4'hf;
      end else begin
         a_q <= port_a_clock;
         b_q <= port_b_clock;
         age_a <= (port_a_clock && !a_q) ? 4'h0 : age_a + 4'(age_a != 4'hf);
         age_b <= (port_b_clock && !b_q) ? 4'h0 : age_b + 4'(age_b != 4'hf);
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         occ <= 4'h0;
      else
         occ <= occ + 4'(pb_in_valid && pb_in_ready)
                - 4'(pb_out_valid && pb_out_ready);
   end
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   rdata_idle_a: assert property (!$past(reg_req.rd) |-> reg_rdata == 32'h0)
      else $error("read data outside a read answer");
   ctrl_read_a: assert property (
      reg_req.rd && reg_req.addr == `CTRL_OFFSET
      |=> reg_rdata == {14'h0, $past(ctrl)})
      else $error("control read differs from written value");
   flag_cause_a: assert property (
      (flags & ~$past(flags) & ~$past(flag_cond)) == 6'h0)
      else $error("flag set without its condition");
   ff1_set_a: assert property (
      $rose(flags.fifo_one_full_flag) |-> age_a <= 4'h6)
      else $error("full flag one set without port A edge");
   ff1_clear_a: assert property (
      $fell(flags.fifo_one_full_flag) |-> (ctrl[8] ? age_a : age_b) <= 4'h6)
      else $error("full flag one cleared by wrong clock");
   ef1_set_a: assert property (
      $rose(flags.fifo_one_empty_flag) |-> age_b <= 4'h6)
      else $error("empty flag one set without port B edge");
   ff2_clear_a: assert property (
      $fell(flags.fifo_two_full_flag) |-> (ctrl[17] ? age_b : age_a) <= 4'h6)
      else $error("full flag two cleared by wrong clock");
   par_flow_a: assert property (
      !ctrl[11] && !$past(ctrl[11]) && !$past(pb_in_valid)
      |-> !port_b_parity_error_flag)
      else $error("flowthrough parity flag without data");
   par_latch_a: assert property (
      ctrl[11] && $past(ctrl[11]) && age_b > 4'h6
      |-> $stable(port_b_parity_error_flag))
      else $error("latched parity flag moved between edges");
   fifo_full_a: assert property (pb_in_ready == (occ != 4'h8))
      else $error("input ready disagrees with fill level");
   cover property ($rose(flags.fifo_two_half_full_flag));
   cover property (ctrl[11] && $rose(port_b_parity_error_flag));
   cover property (!pb_in_ready);
endmodule
bind bififo_flag_parity_control bififo_ctrl_chk chk_u (.clk, .rst_n,
   .port_a_clock, .port_b_clock, .reg_req, .reg_rdata, .flag_cond,
   .flags, .port_b_parity_error_flag, .pb_in_valid, .pb_in_ready,
   .pb_out_valid, .pb_out_ready);
`default_nettype wire

// ---- bififo_ctrl_pkg.sv ----
// types shared by the port B flag and parity control bank
// assumes the constants header is compiled alongside
`include "bififo_ctrl_regs.svh"

package bififo_ctrl_pkg;

   // port B bus width as driven on the width select pins
   typedef enum logic [1:0] {
      WIDTH_WORD = 2'h0,
      WIDTH_HALF = 2'h1,
      WIDTH_BYTE = 2'h2,
      WIDTH_BYTE_ALT = 2'h3
   } width_e;

   // one bit per status flag, condition or registered flag
   typedef struct packed {
      logic fifo_two_half_full_flag;
      logic fifo_two_full_flag;
      logic fifo_two_almost_full_flag;
      logic fifo_one_almost_empty_flag;
      logic fifo_one_empty_flag;
      logic fifo_one_full_flag;
   } flags_s;

   typedef struct packed {
      logic [`ADDR_W-1:0] addr;
      logic [31:0]        wdata;
      logic               wr;
      logic               rd;
   } reg_req_s;

endpackage

// ---- bififo_ctrl_regs.svh ----
// constants of the port B flag and parity control bank
// assumes inclusion by bare name from the design files
`ifndef BIFIFO_CTRL_REGS_SVH
`define BIFIFO_CTRL_REGS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define ADDR_W              8
`define CTRL_OFFSET         8'h00
`define STATUS_OFFSET       8'h04
`define CTRL_W              18
`define CTRL_RESET          18'h00001
`define CTRL_WRITE_MASK     18'h3ff01

// ----------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------
`define CTRL_ODD_PARITY     0
`define CTRL_FF1_SYNC       8
`define CTRL_PAR_SCOPE      9
`define CTRL_PAR_GEN        10
`define CTRL_PAR_LATCH      11
`define CTRL_EF1_SYNC       12
`define CTRL_AE1_SYNC       13
`define CTRL_HF2_LO         14
`define CTRL_HF2_HI         15
`define CTRL_AF2_SYNC       16
`define CTRL_FF2_SYNC       17

// ----------------------------------------------------------------
// status field positions
// ----------------------------------------------------------------
`define STAT_FLAGS_LO       0
`define STAT_PAR_FLAG       6
`define STAT_PAR_STICKY     7
`define STAT_WIDTH_LO       8
`define STAT_OUT_VALID      10
`define STAT_IN_READY       11

// ----------------------------------------------------------------
// data path
// ----------------------------------------------------------------
`define BYTE_W              9
`define BYTES               4
`define WORD_W              36
`define FIFO_DEPTH          8
`define FLAG_COUNT          6

`endif

// ---- bififo_far_end.sv ----
// far side of port B: port clock pulses and a stalling word sink
// assumes the bank's clk; port clocks stand low between pulses
`timescale 1ns/1ps
`default_nettype none
module bififo_far_end (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        stall,
   input  wire logic [35:0] pb_out_data,
   input  wire logic        pb_out_valid,
   output var  logic        pb_out_ready,
   output var  logic        port_a_clock,
   output var  logic        port_b_clock
);
   logic [35:0] got[$];
   initial begin
      port_a_clock = 1'b0;
      port_b_clock = 1'b0;
   end
   assign pb_out_ready = !stall;
   always @(posedge clk) begin
      if (rst_n && pb_out_valid && pb_out_ready)
         got.push_back(pb_out_data);
   end
   // high for two cycles so the pin synchroniser cannot miss it
   task automatic pulse(input logic sel_b);
      @(posedge clk);
      if (sel_b)
         port_b_clock <= 1'b1;
      else
         port_a_clock <= 1'b1;
      repeat (2) @(posedge clk);
      port_a_clock <= 1'b0;
      port_b_clock <= 1'b0;
      repeat (6) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// ---- bififo_flag_parity_control.sv ----
// port B flag clocking and parity control bank of a dual FIFO
// assumes port clocks and width select arrive as pins; flag
// conditions and the port B word stream come from logic on clk
//
// Operation
// - bit 8 low sets fifo one full on a port A edge and clears on port B, high uses port A for both.
// - bit 9 low checks all four bytes, high checks word, half word or byte per width select.
// - bit 10 high overwrites each byte's top bit with parity of its low eight bits.
// - bit 11 low makes the port B parity error flag follow the bus data directly.
// - bit 11 high updates the port B parity error flag only on port B clock edges.
// - bits 12, 13, 16, 17 low set their flags on port B edges and clear on port A edges.
// - bits 12, 13, 16, 17 high set and clear their flags on port B edges only.
// - bits 14-15 pick half-full clocking: LL set on port B and clear on port A, LH port A, HL or HH port B.
// - bit 0 alone selects even or odd parity for both ports.
// - with even parity a correct nine-bit byte has an even count of ones, odd otherwise.
`timescale 1ns/1ps
`default_nettype none
`include "bififo_ctrl_regs.svh"

module bififo_flag_parity_control (
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   input  wire logic                       port_a_clock,
   input  wire logic                       port_b_clock,
   input  wire logic [1:0]                 port_b_width_select,
   input  wire bififo_ctrl_pkg::reg_req_s  reg_req,
   output var  logic [31:0]                reg_rdata,
   input  wire bififo_ctrl_pkg::flags_s    flag_cond,
   output var  bififo_ctrl_pkg::flags_s    flags,
   output var  logic                       port_b_parity_error_flag,
   input  wire logic [`WORD_W-1:0]         pb_in_data,
   input  wire logic                       pb_in_valid,
   output var  logic                       pb_in_ready,
   output var  logic [`WORD_W-1:0]         pb_out_data,
   output var  logic                       pb_out_valid,
   input  wire logic                       pb_out_ready
);

   import bififo_ctrl_pkg::*;

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   // pins and port clock edges
   logic [1:0]          a_sync;
   logic [1:0]          b_sync;
   logic                a_prev;
   logic                b_prev;
   logic                a_edge;
   logic                b_edge;
   logic [1:0]          ws_meta;
   logic [1:0]          ws_sync;
   width_e              width;

   // register bank
   logic [`CTRL_W-1:0]  ctrl;
   logic                par_sticky;
   logic [31:0]         status_word;
   logic                wr_ctrl;
   logic                wr_status;

   // flag clocking
   logic [`FLAG_COUNT-1:0] cond_vec;
   logic [`FLAG_COUNT-1:0] flag_vec;
   logic [`FLAG_COUNT-1:0] set_on_b;
   logic [`FLAG_COUNT-1:0] clr_on_b;
   logic [`FLAG_COUNT-1:0] set_edge;
   logic [`FLAG_COUNT-1:0] clr_edge;
   logic [1:0]          hf_mode;

   // port B data path
   logic                odd;
   logic [`BYTES-1:0]   byte_bad;
   logic [`BYTES-1:0]   byte_scope;
   logic                par_err_now;
   logic [`WORD_W-1:0]  gen_data;
   logic                fifo_in_ready;
   logic [`WORD_W-1:0]  fifo_out_data;
   logic                fifo_out_valid;

   // ----------------------------------------------------------------
   // pin synchronisers and port clock edges
   // ----------------------------------------------------------------
   // first stage feeds only the second stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         a_sync <= 2'h0;
      end else begin
         a_sync <= {a_sync[0], port_a_clock};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         b_sync <= 2'h0;
      end else begin
         b_sync <= {b_sync[0], port_b_clock};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         a_prev <= 1'b0;
      end else begin
         a_prev <= a_sync[1];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         b_prev <= 1'b0;
      end else begin
         b_prev <= b_sync[1];
      end
   end

   // port clocks must stay well below clk/4 to be seen
   // each level must last two clk or the edge is lost
   assign a_edge = a_sync[1] && !a_prev;
   assign b_edge = b_sync[1] && !b_prev;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ws_meta <= 2'h0;
         ws_sync <= 2'h0;
      end else begin
         ws_meta <= port_b_width_select;
         ws_sync <= ws_meta;
      end
   end

   // a width change acts two clk late
   assign width = width_e'(ws_sync);

   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   assign wr_ctrl   = reg_req.wr && (reg_req.addr == `CTRL_OFFSET);
   assign wr_status = reg_req.wr && (reg_req.addr == `STATUS_OFFSET);

   // port A bits 1-7 live elsewhere and read as zero here
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= `CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl <= reg_req.wdata[`CTRL_W-1:0] & `CTRL_WRITE_MASK;
      end
   end

   always_comb begin
      status_word = 32'h0;
      status_word[`STAT_FLAGS_LO +: `FLAG_COUNT] = flag_vec;
      status_word[`STAT_PAR_FLAG]                = port_b_parity_error_flag;
      status_word[`STAT_PAR_STICKY]              = par_sticky;
      status_word[`STAT_WIDTH_LO +: 2]           = ws_sync;
      status_word[`STAT_OUT_VALID]               = fifo_out_valid;
      status_word[`STAT_IN_READY]                = fifo_in_ready;
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 32'h0;
      end else if (reg_req.rd) begin
         case (reg_req.addr)
            `CTRL_OFFSET: begin
               reg_rdata <= {14'h0, ctrl};
            end
            `STATUS_OFFSET: begin
               reg_rdata <= status_word;
            end
            default: begin
               reg_rdata <= 32'h0;
            end
         endcase
      end else begin
         reg_rdata <= 32'h0;
      end
   end

   // ----------------------------------------------------------------
   // flag clocking selection
   // ----------------------------------------------------------------
   // index order follows flags_s: 0 ff1 .. 5 hf2
   assign cond_vec = flag_cond;
   assign hf_mode  = {ctrl[`CTRL_HF2_LO], ctrl[`CTRL_HF2_HI]};

   always_comb begin
      set_on_b = '0;
      clr_on_b = '0;

      // fifo one full: written by A, read by B
      set_on_b[0] = 1'b0;
      clr_on_b[0] = !ctrl[`CTRL_FF1_SYNC];

      // far FIFOs set on B and clear on A unless synchronous
      // empty one
      set_on_b[1] = 1'b1;
      clr_on_b[1] = ctrl[`CTRL_EF1_SYNC];

      // almost empty one
      set_on_b[2] = 1'b1;
      clr_on_b[2] = ctrl[`CTRL_AE1_SYNC];

      // almost full two
      set_on_b[3] = 1'b1;
      clr_on_b[3] = ctrl[`CTRL_AF2_SYNC];

      // full two
      set_on_b[4] = 1'b1;
      clr_on_b[4] = ctrl[`CTRL_FF2_SYNC];

      // half full: first digit is bit 14, second bit 15
      case (hf_mode)
         // LL: set on B, clear on A
         2'h0: begin
            set_on_b[5] = 1'b1;
            clr_on_b[5] = 1'b0;
         end
         // LH: port A only
         2'h1: begin
            set_on_b[5] = 1'b0;
            clr_on_b[5] = 1'b0;
         end
         // HL, HH: port B only
         default: begin
            set_on_b[5] = 1'b1;
            clr_on_b[5] = 1'b1;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // flag registers
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < `FLAG_COUNT; gi = gi + 1) begin : g_flag
         assign set_edge[gi] = set_on_b[gi] ? b_edge : a_edge;
         assign clr_edge[gi] = clr_on_b[gi] ? b_edge : a_edge;

         // a flag sets only on an edge of its set clock and clears only on an edge of its clear clock
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               flag_vec[gi] <= 1'b0;
            end else if (cond_vec[gi] && set_edge[gi]) begin
               flag_vec[gi] <= 1'b1;
            end else if (!cond_vec[gi] && clr_edge[gi]) begin
               flag_vec[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   assign flags = flag_vec;

   // ----------------------------------------------------------------
   // parity check
   // ----------------------------------------------------------------
   assign odd = ctrl[`CTRL_ODD_PARITY];

   always_comb begin
      byte_bad = '0;
      for (int i = 0; i < `BYTES; i++) begin
         byte_bad[i] = (^pb_in_data[i*`BYTE_W +: `BYTE_W]) != odd;
      end
   end

   // scope narrows to the active lanes only when bit 9 asks
   always_comb begin
      byte_scope = 4'hf;
      if (ctrl[`CTRL_PAR_SCOPE]) begin
         case (width)
            WIDTH_WORD: begin
               byte_scope = 4'hf;
            end
            WIDTH_HALF: begin
               byte_scope = 4'h3;
            end
            default: begin
               byte_scope = 4'h1;
            end
         endcase
      end
   end

   assign par_err_now = |(byte_bad & byte_scope) && pb_in_valid;

   // flowthrough is one clk behind the bus so the output is a flop
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         port_b_parity_error_flag <= 1'b0;
      end else if (!ctrl[`CTRL_PAR_LATCH]) begin
         port_b_parity_error_flag <= par_err_now;
      end else if (b_edge) begin
         port_b_parity_error_flag <= par_err_now;
      end
   end

   // sticky copy for software; a new error beats the clear
   // cleared by writing one to status bit 7
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         par_sticky <= 1'b0;
      end else if (par_err_now && pb_in_ready) begin
         par_sticky <= 1'b1;
      end else if (wr_status && reg_req.wdata[`STAT_PAR_STICKY]) begin
         par_sticky <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // parity generation
   // ----------------------------------------------------------------
   // same sense bit as the check, which sees raw data
   always_comb begin
      gen_data = pb_in_data;
      if (ctrl[`CTRL_PAR_GEN]) begin
         for (int i = 0; i < `BYTES; i++) begin
            gen_data[i*`BYTE_W + `BYTE_W - 1] =
               (^pb_in_data[i*`BYTE_W +: `BYTE_W - 1]) ^ odd;
         end
      end
   end

   // ----------------------------------------------------------------
   // data buffer
   // ----------------------------------------------------------------
   // rides out a short stall of the far side
   word_fifo #(
      .WIDTH (`WORD_W),
      .DEPTH (`FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_data   (gen_data),
      .in_valid  (pb_in_valid),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_out_data),
      .out_valid (fifo_out_valid),
      .out_ready (pb_out_ready)
   );

   assign pb_in_ready  = fifo_in_ready;
   assign pb_out_data  = fifo_out_data;
   assign pb_out_valid = fifo_out_valid;

endmodule

`default_nettype wire

// ---- bififo_flag_parity_control_tb_top.sv ----
// self-checking bench of the port B flag and parity control bank
// assumes the package, the bank, its checker and the far-end model
`timescale 1ns/1ps
`default_nettype none
`include "bififo_ctrl_regs.svh"
module bififo_flag_parity_control_tb_top;
   import bififo_ctrl_pkg::*;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        stall = 1'b0;
   logic [1:0]  wsel = 2'h0;
   reg_req_s    req = '0;
   flags_s      cond = '0;
   flags_s      flags;
   logic [35:0] din = 36'h0;
   logic        din_v = 1'b0;
   logic [31:0] rdata;
   logic [35:0] dout;
   logic        perr, in_rdy, out_v, out_rdy, ca, cb;
   int          fail_count = 0;
   int          checks = 0;
   always #12.5 clk = ~clk;
   bififo_flag_parity_control dut_u (.clk(clk), .rst_n(rst_n),
      .port_a_clock(ca), .port_b_clock(cb), .port_b_width_select(wsel),
      .reg_req(req), .reg_rdata(rdata), .flag_cond(cond), .flags(flags),
      .port_b_parity_error_flag(perr), .pb_in_data(din),
      .pb_in_valid(din_v), .pb_in_ready(in_rdy), .pb_out_data(dout),
      .pb_out_valid(out_v), .pb_out_ready(out_rdy));
   bififo_far_end far_u (.clk(clk), .rst_n(rst_n), .stall(stall),
      .pb_out_data(dout), .pb_out_valid(out_v), .pb_out_ready(out_rdy),
      .port_a_clock(ca), .port_b_clock(cb));
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic check(string what, logic [35:0] seen, logic [35:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a, logic [31:0] exp);
      @(posedge clk);
      req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req.rd <= 1'b0;
      #1 check("read data", 36'(rdata), 36'(exp));
   endtask
   task automatic push(logic [35:0] w);
      @(posedge clk);
      din <= w;
      din_v <= 1'b1;
      @(posedge clk);
      din_v <= 1'b0;
   endtask
   function automatic logic [35:0] wordf(int bad, logic odd);
      logic [7:0] b;
      for (int k = 0; k < 4; k++) begin
         b = 8'h35 + 8'(k * 7);
         wordf[9*k +: 9] = {^b ^ odd ^ (k == bad), b};
      end
   endfunction
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_regs();
      rd(`CTRL_OFFSET, 32'h1);
      wr(`CTRL_OFFSET, 32'hffffffff);
      rd(`CTRL_OFFSET, 32'h3ff01);
      rd(8'h40, 32'h0);
   endtask
   // a clock that may not act is pulsed before the one that may
   task automatic flag_case(int i, logic [17:0] c, logic set_b, clr_b);
      wr(`CTRL_OFFSET, {14'h0, c});
      cond[i] <= 1'b1;
      if (set_b != clr_b) begin
         far_u.pulse(clr_b);
         check("flag early", 36'(flags[i]), 36'h0);
      end
      far_u.pulse(set_b);
      check("flag set", 36'(flags[i]), 36'h1);
      cond[i] <= 1'b0;
      far_u.pulse(!clr_b);
      check("flag held", 36'(flags[i]), 36'h1);
      far_u.pulse(clr_b);
      check("flag clear", 36'(flags[i]), 36'h0);
   endtask
   task automatic t_flags();
      int bits[4] = '{12, 13, 16, 17};
      flag_case(0, 18'h00001, 1'b0, 1'b1);
      flag_case(0, 18'h00101, 1'b0, 1'b0);
      for (int i = 1; i < 5; i++) begin
         flag_case(i, 18'h00001, 1'b1, 1'b0);
         flag_case(i, 18'h00001 | (18'h1 << bits[i-1]), 1'b1, 1'b1);
      end
      flag_case(5, 18'h00001, 1'b1, 1'b0);
      flag_case(5, 18'h08001, 1'b0, 1'b0);
      flag_case(5, 18'h04001, 1'b1, 1'b1);
      flag_case(5, 18'h0c001, 1'b1, 1'b1);
   endtask
   task automatic t_parity();
      for (int s = 0; s < 2; s++) begin
         wr(`CTRL_OFFSET, 32'(s));
         push(wordf(3, s[0]));
         #1 check("bad word flag", 36'(perr), 36'h1);
         push(wordf(9, s[0]));
         #1 check("good word flag", 36'(perr), 36'h0);
         @(posedge clk);
         #1 check("idle flag", 36'(perr), 36'h0);
      end
      wr(`CTRL_OFFSET, 32'h201);
      wsel <= 2'h2;
      repeat (4) @(posedge clk);
      push(wordf(3, 1'b1));
      #1 check("byte scope top", 36'(perr), 36'h0);
      push(wordf(0, 1'b1));
      #1 check("byte scope low", 36'(perr), 36'h1);
      wsel <= 2'h0;
      repeat (4) @(posedge clk);
      push(wordf(3, 1'b1));
      #1 check("word scope top", 36'(perr), 36'h1);
      @(posedge clk);
      #1 far_u.got.delete();
      push(wordf(2, 1'b1));
      wr(`CTRL_OFFSET, 32'h401);
      push(wordf(2, 1'b1));
      repeat (4) @(posedge clk);
      check("no generation", far_u.got[0], wordf(2, 1'b1));
      check("generation", far_u.got[1], wordf(9, 1'b1));
   endtask
   // latched flag while the buffer fills to refusal and then drains
   task automatic t_latch();
      wr(`CTRL_OFFSET, 32'h801);
      far_u.got.delete();
      stall <= 1'b1;
      din <= wordf(0, 1'b1);
      din_v <= 1'b1;
      repeat (12) @(posedge clk);
      #1 check("full refuses", 36'(in_rdy), 36'h0);
      check("latched quiet", 36'(perr), 36'h0);
      far_u.pulse(1'b1);
      check("latched set", 36'(perr), 36'h1);
      din_v <= 1'b0;
      repeat (4) @(posedge clk);
      #1 check("latched hold", 36'(perr), 36'h1);
      far_u.pulse(1'b1);
      check("latched clear", 36'(perr), 36'h0);
      stall <= 1'b0;
      repeat (12) @(posedge clk);
      check("drained words", 36'(far_u.got.size()), 36'h8);
      check("drained data", far_u.got[7], wordf(0, 1'b1));
      check("empty", 36'(out_v), 36'h0);
      rd(`STATUS_OFFSET, 32'h880);
      wr(`STATUS_OFFSET, 32'h80);
      rd(`STATUS_OFFSET, 32'h800);
   endtask
   initial begin
      #250000;
      fail_count++;
      end_sim();
   end
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_flags();
      t_parity();
      t_latch();
      end_sim();
   end
endmodule
`default_nettype wire

// ---- word_fifo.sv ----
// small synchronous FIFO with valid/ready on both sides
// assumes one clock and an asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none

module word_fifo #(
   parameter int WIDTH = 36,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output var  logic             in_ready,
   output var  logic [WIDTH-1:0] out_data,
   output var  logic             out_valid,
   input  wire logic             out_ready
);

   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wr_ptr;
   logic [PW-1:0]    rd_ptr;
   logic [CW-1:0]    count;
   logic             push;
   logic             pop;
   logic [CW-1:0]    next_count;

   assign push = in_valid && in_ready;
   assign pop  = out_valid && out_ready;
   assign out_data = mem[rd_ptr];

   always_comb begin
      next_count = count;
      if (push && !pop) begin
         next_count = count + CW'(1);
      end else if (pop && !push) begin
         next_count = count - CW'(1);
      end
   end

   // flags registered from the next count so both ports see flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count     <= '0;
         in_ready  <= 1'b1;
         out_valid <= 1'b0;
      end else begin
         count     <= next_count;
         in_ready  <= (next_count != CW'(DEPTH));
         out_valid <= (next_count != '0);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
         end
      end
   end

   // storage has no reset; only written slots are ever read
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

endmodule

`default_nettype wire
